// ### common/uart_fss_pkg.sv
package uart_fss_pkg;
    // bus and field widths
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned BE_W        = 4;
    localparam int unsigned REG_W       = 16;
    localparam int unsigned LEVEL_W     = 16;
    localparam int unsigned DEPTH_DEF   = 16;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned THR_W       = 8;
    localparam int unsigned IRQ_W       = 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_FIFO_STATUS   = 32'h5000107C;
    localparam logic [ADDR_W-1:0] OFS_TX_FILL       = 32'h50001080;
    localparam logic [ADDR_W-1:0] OFS_RX_FILL       = 32'h50001084;
    localparam logic [ADDR_W-1:0] OFS_SOFT_RESET    = 32'h50001088;
    localparam logic [ADDR_W-1:0] OFS_SEND_SHADOW   = 32'h5000108C;
    localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL    = 32'h500010C0;
    localparam logic [ADDR_W-1:0] OFS_QUEUE_CTRL    = 32'h500010C4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS    = 32'h500010C8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 32'h500010CC;

    // fifo_status fields
    localparam int unsigned ST_RX_FULL_BIT  = 4;
    localparam int unsigned ST_RX_NE_BIT    = 3;
    localparam int unsigned ST_TX_EMPTY_BIT = 2;
    localparam int unsigned ST_TX_NF_BIT    = 1;
    // software_reset fields
    localparam int unsigned SR_TX_CLR_BIT   = 2;
    localparam int unsigned SR_RX_CLR_BIT   = 1;
    localparam int unsigned SR_CTRL_RST_BIT = 0;
    // send_request_shadow field
    localparam int unsigned SH_RTS_BIT      = 0;
    // modem_control_register fields
    localparam int unsigned MC_RTS_BIT      = 1;
    localparam int unsigned MC_LOOP_BIT     = 4;
    localparam int unsigned MC_AFC_BIT      = 5;
    // queue_control_register fields
    localparam int unsigned QC_EN_BIT       = 0;
    localparam int unsigned QC_RX_CLR_BIT   = 1;
    localparam int unsigned QC_TX_CLR_BIT   = 2;
    localparam int unsigned QC_THR_LSB      = 8;
    // interrupt fields
    localparam int unsigned IRQ_RX_FULL_BIT  = 0;
    localparam int unsigned IRQ_TX_EMPTY_BIT = 1;

    // reset values
    localparam logic [REG_W-1:0]   MC_RST       = 16'h0000;
    localparam logic               QC_EN_RST    = 1'h0;
    localparam logic [THR_W-1:0]   QC_THR_RST   = 8'h00;
    localparam logic [IRQ_W-1:0]   IRQ_RST      = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_RST    = 16'h0000;
    localparam logic [DATA_W-1:0]  RDATA_RST    = 32'h00000000;
    localparam logic               RTS_N_RST    = 1'h1;
endpackage : uart_fss_pkg

// ### src/queue_level_counter.sv
`timescale 1ns/1ps
`default_nettype none
module queue_level_counter #(
    parameter int unsigned DEPTH   = uart_fss_pkg::DEPTH_DEF,
    parameter int unsigned LEVEL_W = uart_fss_pkg::LEVEL_W
) (
    input  wire logic               clk_i,
    input  wire logic               clear_i,
    input  wire logic               push_i,
    input  wire logic               pop_i,
    output logic [LEVEL_W-1:0]      level_o,
    output logic                    full_o,
    output logic                    empty_o
);
    import uart_fss_pkg::*;

    localparam logic [LEVEL_W-1:0] DEPTH_L = LEVEL_W'(DEPTH);

    logic [LEVEL_W-1:0] level_r;
    logic               push_ok;
    logic               pop_ok;

    // a push into a full queue or a pop from an empty one is dropped
    assign push_ok = push_i & ~full_o;
    assign pop_ok  = pop_i & ~empty_o;
    assign full_o  = (level_r == DEPTH_L);
    assign empty_o = (level_r == LEVEL_RST);
    assign level_o = level_r;

    // fill count; clear wins over any push or pop in the same cycle
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            level_r <= LEVEL_RST;
        end else if (push_ok & ~pop_ok) begin
            level_r <= level_r + LEVEL_W'(1);
        end else if (pop_ok & ~push_ok) begin
            level_r <= level_r - LEVEL_W'(1);
        end
    end

    // the count never passes the depth
    level_bound_a: assert property (@(posedge clk_i) disable iff (clear_i)
        level_r <= DEPTH_L)
        else $error("fill level above depth");

    // a clear empties the queue at the next edge
    level_clear_a: assert property (@(posedge clk_i)
        clear_i |=> (level_r == LEVEL_RST))
        else $error("fill level not zero after clear");
endmodule : queue_level_counter
`default_nettype wire

// ### src/ctrl_reset_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_reset_sync #(
    parameter int unsigned STAGES = uart_fss_pkg::SYNC_STAGES
) (
    input  wire logic   clk_i,
    input  wire logic   async_rst_i,
    input  wire logic   sync_rst_i,
    output logic        rst_o
);
    import uart_fss_pkg::*;

    logic [STAGES-1:0] hold_r;

    // asserts at once, releases only after STAGES clock edges
    always_ff @(posedge clk_i or posedge async_rst_i) begin
        if (async_rst_i) begin
            hold_r <= '1;
        end else if (sync_rst_i) begin
            hold_r <= '1;
        end else begin
            hold_r <= {hold_r[STAGES-2:0], 1'b0};
        end
    end

    assign rst_o = hold_r[STAGES-1];
endmodule : ctrl_reset_sync
`default_nettype wire

// ### src/uart_fifo_status_reset_shadow.sv
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_status_reset_shadow #(
    parameter int unsigned DEPTH = uart_fss_pkg::DEPTH_DEF
) (
    input  wire logic                              clk_i,
    input  wire logic                              sys_rst_i,
    input  wire logic [uart_fss_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic [uart_fss_pkg::BE_W-1:0]     avs_byteenable_i,
    input  wire logic                              avs_read_i,
    input  wire logic                              avs_write_i,
    input  wire logic [uart_fss_pkg::DATA_W-1:0]   avs_writedata_i,
    output logic [uart_fss_pkg::DATA_W-1:0]        avs_readdata_o,
    output logic                                   avs_waitrequest_o,
    input  wire logic                              tx_push_i,
    input  wire logic                              tx_pop_i,
    input  wire logic                              rx_push_i,
    input  wire logic                              rx_pop_i,
    output logic                                   fifo_enable_o,
    output logic                                   auto_flow_o,
    output logic                                   loopback_o,
    output logic                                   rts_n_o,
    output logic                                   loop_cts_o,
    output logic                                   ctrl_rst_o,
    output logic                                   irq_o
);
    import uart_fss_pkg::*;

    localparam logic [LEVEL_W-1:0] DEPTH_L = LEVEL_W'(DEPTH);

    logic                 ack_r, bus_req, wr_en, rd_cap;
    logic [REG_W-1:0]     lane_mask, wdata_m, status_val, mc_r;
    logic                 hit_srr, hit_qc, hit_mc, hit_sh, hit_is, hit_im;
    logic [DATA_W-1:0]    rd_val, readdata_r;
    logic                 ur_req_r, ctrl_rst, any_rst;
    logic                 fifo_en_r, fifo_dis, tx_clr, rx_clr;
    logic [THR_W-1:0]     rx_thr_r;
    logic [LEVEL_W-1:0]   tx_level, rx_level;
    logic                 tx_full, tx_empty, rx_full, rx_empty;
    logic                 mc_rts, mc_loop, mc_afc, thr_hit;
    logic                 rts_n_nxt, rts_n_r, loop_cts_r;
    logic                 rx_full_d_r, tx_empty_d_r, irq_r;
    logic [IRQ_W-1:0]     irq_set, irq_status_r, irq_mask_r;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: every access is answered at the second edge

    assign bus_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_r;
    assign wr_en             = avs_write_i & ack_r;
    assign rd_cap            = avs_read_i & ~ack_r;
    assign avs_readdata_o    = readdata_r;

    // one-cycle wait then acknowledge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    // byte lanes gate the write data; a disabled lane leaves its fields unchanged and sets no clear bit
    assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wdata_m   = avs_writedata_i[REG_W-1:0] & lane_mask;

    // address decode
    assign hit_srr = (avs_address_i == OFS_SOFT_RESET);
    assign hit_qc  = (avs_address_i == OFS_QUEUE_CTRL);
    assign hit_mc  = (avs_address_i == OFS_MODEM_CTRL);
    assign hit_sh  = (avs_address_i == OFS_SEND_SHADOW);
    assign hit_is  = (avs_address_i == OFS_IRQ_STATUS);
    assign hit_im  = (avs_address_i == OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // read path

    // status word; reserved bits stay zero
    always_comb begin
        status_val                  = '0;
        status_val[ST_RX_FULL_BIT]  = rx_full;
        status_val[ST_RX_NE_BIT]    = ~rx_empty;
        status_val[ST_TX_EMPTY_BIT] = tx_empty;
        status_val[ST_TX_NF_BIT]    = ~tx_full;
    end

    // read mux; unmapped and write-only locations read zero
    always_comb begin
        rd_val = '0;
        case (avs_address_i)
            OFS_FIFO_STATUS: rd_val[REG_W-1:0] = status_val;
            OFS_TX_FILL:     rd_val[LEVEL_W-1:0] = tx_level;
            OFS_RX_FILL:     rd_val[LEVEL_W-1:0] = rx_level;
            OFS_SEND_SHADOW: rd_val[SH_RTS_BIT] = mc_rts;
            OFS_MODEM_CTRL:  rd_val[REG_W-1:0] = mc_r;
            OFS_QUEUE_CTRL: begin
                rd_val[QC_EN_BIT] = fifo_en_r;
                rd_val[QC_THR_LSB +: THR_W] = rx_thr_r;
            end
            OFS_IRQ_STATUS:  rd_val[IRQ_W-1:0] = irq_status_r;
            OFS_IRQ_MASK:    rd_val[IRQ_W-1:0] = irq_mask_r;
            default:         rd_val = '0;
        endcase
    end

    // read data held from the first cycle of a read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            readdata_r <= RDATA_RST;
        end else if (rd_cap) begin
            readdata_r <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // whole-controller reset

    // request pulse lasts one cycle; zero writes leave it low
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ur_req_r <= 1'b0;
        end else begin
            ur_req_r <= wr_en & hit_srr & wdata_m[SR_CTRL_RST_BIT];
        end
    end

    // asynchronous assertion, clocked release
    ctrl_reset_sync #(
        .STAGES      (SYNC_STAGES)
    ) u_ctrl_rst (
        .clk_i       (clk_i),
        .async_rst_i (ur_req_r),
        .sync_rst_i  (sys_rst_i),
        .rst_o       (ctrl_rst)
    );

    // the serial-clock side takes the same reset and syncs its release
    assign ctrl_rst_o = ctrl_rst;
    assign any_rst    = sys_rst_i | ctrl_rst;

    ////////////////////////////////////////////////////////////////////////
    // modem and queue control

    // modem control; the shadow touches only the send bit
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            mc_r <= MC_RST;
        end else if (wr_en & hit_mc & avs_byteenable_i[0]) begin
            mc_r[MC_RTS_BIT]  <= wdata_m[MC_RTS_BIT];
            mc_r[MC_LOOP_BIT] <= wdata_m[MC_LOOP_BIT];
            mc_r[MC_AFC_BIT]  <= wdata_m[MC_AFC_BIT];
        end else if (wr_en & hit_sh & avs_byteenable_i[0]) begin
            mc_r[MC_RTS_BIT] <= wdata_m[SH_RTS_BIT];
        end
    end

    assign mc_rts  = mc_r[MC_RTS_BIT];
    assign mc_loop = mc_r[MC_LOOP_BIT];
    assign mc_afc  = mc_r[MC_AFC_BIT];

    // queue enable and receive threshold
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            fifo_en_r <= QC_EN_RST;
        end else if (wr_en & hit_qc & avs_byteenable_i[0]) begin
            fifo_en_r <= wdata_m[QC_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rx_thr_r <= QC_THR_RST;
        end else if (wr_en & hit_qc & avs_byteenable_i[1]) begin
            rx_thr_r <= wdata_m[QC_THR_LSB +: THR_W];
        end
    end

    // clear requests are pulses, so nothing needs releasing
    assign fifo_dis = wr_en & hit_qc & avs_byteenable_i[0] & fifo_en_r &
                      ~wdata_m[QC_EN_BIT];
    assign tx_clr = any_rst | fifo_dis |
                    (wr_en & hit_srr & wdata_m[SR_TX_CLR_BIT]) |
                    (wr_en & hit_qc & wdata_m[QC_TX_CLR_BIT]);
    assign rx_clr = any_rst | fifo_dis |
                    (wr_en & hit_srr & wdata_m[SR_RX_CLR_BIT]) |
                    (wr_en & hit_qc & wdata_m[QC_RX_CLR_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // fill counters

    queue_level_counter #(
        .DEPTH   (DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_tx_level (
        .clk_i   (clk_i),
        .clear_i (tx_clr),
        .push_i  (tx_push_i),
        .pop_i   (tx_pop_i),
        .level_o (tx_level),
        .full_o  (tx_full),
        .empty_o (tx_empty)
    );

    queue_level_counter #(
        .DEPTH   (DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_rx_level (
        .clk_i   (clk_i),
        .clear_i (rx_clr),
        .push_i  (rx_push_i),
        .pop_i   (rx_pop_i),
        .level_o (rx_level),
        .full_o  (rx_full),
        .empty_o (rx_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // request-to-send pin

    assign thr_hit = (rx_level > LEVEL_W'(rx_thr_r));

    // low means ready to exchange data
    always_comb begin
        if (mc_loop) begin
            rts_n_nxt = 1'b1;
        end else if (mc_afc & fifo_en_r) begin
            rts_n_nxt = ~(mc_rts & ~thr_hit);
        end else begin
            rts_n_nxt = ~mc_rts;
        end
    end

    // pin and loopback return are registered
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rts_n_r    <= RTS_N_RST;
            loop_cts_r <= 1'b0;
        end else begin
            rts_n_r    <= rts_n_nxt;
            loop_cts_r <= mc_loop & mc_rts;
        end
    end

    assign rts_n_o       = rts_n_r;
    assign loop_cts_o    = loop_cts_r;
    assign fifo_enable_o = fifo_en_r;
    assign auto_flow_o   = mc_afc;
    assign loopback_o    = mc_loop;

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky on rising full / empty, write one to clear

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rx_full_d_r  <= 1'b0;
            tx_empty_d_r <= 1'b1;
        end else begin
            rx_full_d_r  <= rx_full;
            tx_empty_d_r <= tx_empty;
        end
    end

    assign irq_set[IRQ_RX_FULL_BIT]  = rx_full & ~rx_full_d_r;
    assign irq_set[IRQ_TX_EMPTY_BIT] = tx_empty & ~tx_empty_d_r;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            irq_status_r <= IRQ_RST;
        end else if (wr_en & hit_is) begin
            irq_status_r <= (irq_status_r & ~wdata_m[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status_r <= irq_status_r | irq_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            irq_mask_r <= IRQ_RST;
        end else if (wr_en & hit_im & avs_byteenable_i[0]) begin
            irq_mask_r <= wdata_m[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    assign irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    rx_flags_read_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (rd_cap && avs_address_i == OFS_FIFO_STATUS) |=>
        (avs_readdata_o[ST_RX_FULL_BIT] == ($past(rx_level) == DEPTH_L)) &&
        (avs_readdata_o[ST_RX_NE_BIT] == ($past(rx_level) != LEVEL_RST)))
        else $error("receive flags wrong");
    tx_flags_read_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (rd_cap && avs_address_i == OFS_FIFO_STATUS) |=>
        (avs_readdata_o[ST_TX_EMPTY_BIT] == ($past(tx_level) == LEVEL_RST)) &&
        (avs_readdata_o[ST_TX_NF_BIT] == ($past(tx_level) != DEPTH_L)))
        else $error("transmit flags wrong");
    level_read_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (rd_cap && avs_address_i == OFS_RX_FILL) |=>
        (avs_readdata_o == {16'h0000, $past(rx_level)}))
        else $error("receive level read wrong");
    tx_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && (hit_srr || hit_qc) && wdata_m[SR_TX_CLR_BIT]) |=>
        (tx_level == LEVEL_RST) ##1 (avs_waitrequest_o || !avs_write_i))
        else $error("transmit clear missed");
    rx_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && hit_srr && wdata_m[SR_RX_CLR_BIT]) |=>
        (rx_level == LEVEL_RST))
        else $error("receive clear missed");
    self_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (rd_cap && avs_address_i == OFS_SOFT_RESET) |=>
        (avs_readdata_o == RDATA_RST))
        else $error("reset register reads nonzero");
    soft_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && hit_srr && wdata_m[SR_CTRL_RST_BIT]) |=> ctrl_rst_o[*3])
        else $error("controller reset too short");
    zero_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && hit_srr && wdata_m[2:0] == 3'h0 && !ur_req_r &&
         !ctrl_rst_o) |=> !ctrl_rst_o)
        else $error("zero write caused reset");
    shadow_rts_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (wr_en && hit_sh && avs_byteenable_i[0]) |=>
        (mc_rts == $past(avs_writedata_i[SH_RTS_BIT])))
        else $error("shadow send bit not stored");
    rts_direct_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (!mc_loop && !mc_afc) |=> (rts_n_o == !$past(mc_rts)))
        else $error("rts_n not following send bit");
    rts_gate_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (mc_afc && fifo_en_r && !mc_loop && thr_hit) |=> rts_n_o)
        else $error("rts_n low above threshold");
    rts_loop_a: assert property (@(posedge clk_i) disable iff (any_rst)
        mc_loop |=> (rts_n_o && loop_cts_o == $past(mc_rts)))
        else $error("loopback rts handling wrong");
    fifo_disable_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fifo_dis |=> (tx_level == LEVEL_RST && rx_level == LEVEL_RST))
        else $error("disable did not empty queues");
endmodule : uart_fifo_status_reset_shadow
`default_nettype wire

// ### verif/modem_partner.sv
`timescale 1ns/1ps
`default_nettype none
// modem side: a low send request means the controller is ready
module modem_partner (
    input  wire logic rts_n_i,
    output logic      ready_o
);
    assign ready_o = ~rts_n_i;
endmodule : modem_partner
`default_nettype wire

// ### verif/uart_fifo_status_reset_shadow_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_status_reset_shadow_bench;
    import uart_fss_pkg::*;
    logic        clk_i = 0, sys_rst_i = 1, rd = 0, wr = 0;
    logic [31:0] addr = '0, wd = '0, rdata;
    logic [3:0]  q = '0; // tx push, tx pop, rx push, rx pop
    logic        wreq, fen, afc, lb, rts_n, lcts, crst, irq, ready;
    int          failures = 0, compares = 0, cyc = 0;
    uart_fifo_status_reset_shadow #(.DEPTH(4)) uut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .avs_address_i(addr),
        .avs_byteenable_i(4'hF), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .tx_push_i(q[3]), .tx_pop_i(q[2]),
        .rx_push_i(q[1]), .rx_pop_i(q[0]), .fifo_enable_o(fen),
        .auto_flow_o(afc), .loopback_o(lb), .rts_n_o(rts_n),
        .loop_cts_o(lcts), .ctrl_rst_o(crst), .irq_o(irq));
    modem_partner modem (.rts_n_i(rts_n), .ready_o(ready));
    always #12.5 clk_i = ~clk_i;
    // cut a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [15:0] d, output logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        wd <= {16'h0000, d};
        rd <= ~w;
        wr <= w;
        @(posedge clk_i);
        while (wreq !== 1'b0) @(posedge clk_i);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc
    task automatic wrt(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] v;
        acc(1'b1, a, d, v);
    endtask : wrt
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        acc(1'b0, a, 16'h0000, v);
        chk(v, exp);
    endtask : rc
    task automatic pul(input logic [3:0] m, input int n);
        repeat (n) begin
            @(posedge clk_i) q <= m;
            @(posedge clk_i) q <= 4'h0;
        end
    endtask : pul
    task automatic t_fill();
        rc(OFS_FIFO_STATUS, 32'h00000006);
        rc(OFS_TX_FILL, 32'h0);
        rc(OFS_SOFT_RESET, 32'h0);
        pul(4'hA, 4);
        rc(OFS_FIFO_STATUS, 32'h00000018);
        rc(OFS_TX_FILL, 32'h4);
        wrt(OFS_SOFT_RESET, 16'h0000);
        rc(OFS_RX_FILL, 32'h4);
        pul(4'h1, 1);
        rc(OFS_FIFO_STATUS, 32'h00000008);
        wrt(OFS_SOFT_RESET, 16'h0004);
        rc(OFS_TX_FILL, 32'h0);
        rc(OFS_RX_FILL, 32'h3);
        wrt(OFS_SOFT_RESET, 16'h0002);
        rc(OFS_FIFO_STATUS, 32'h00000006);
    endtask : t_fill
    task automatic t_irq();
        rc(OFS_IRQ_STATUS, 32'h3);
        chk(irq, 1'b0);
        wrt(OFS_IRQ_MASK, 16'h0002);
        rc(OFS_IRQ_MASK, 32'h2);
        chk(irq, 1'b1);
        wrt(OFS_IRQ_STATUS, 16'h0003);
        rc(OFS_IRQ_STATUS, 32'h0);
        chk(irq, 1'b0);
    endtask : t_irq
    task automatic t_queue_ctrl();
        pul(4'hA, 2);
        wrt(OFS_QUEUE_CTRL, 16'h0005);
        rc(OFS_TX_FILL, 32'h0);
        wrt(OFS_QUEUE_CTRL, 16'h0003);
        rc(OFS_RX_FILL, 32'h0);
        rc(OFS_QUEUE_CTRL, 32'h1);
        pul(4'hA, 1);
        wrt(OFS_QUEUE_CTRL, 16'h0000);
        rc(OFS_TX_FILL, 32'h0);
        rc(OFS_RX_FILL, 32'h0);
    endtask : t_queue_ctrl
    task automatic t_rts();
        wrt(OFS_SEND_SHADOW, 16'h0001);
        rc(OFS_MODEM_CTRL, 32'h2);
        chk(rts_n, 1'b0);
        chk(ready, 1'b1);
        wrt(OFS_MODEM_CTRL, 16'h0012);
        rc(OFS_SEND_SHADOW, 32'h1);
        chk({rts_n, lcts, lb}, 3'b111);
        wrt(OFS_QUEUE_CTRL, 16'h0101);
        wrt(OFS_MODEM_CTRL, 16'h0022);
        pul(4'h2, 1);
        rc(OFS_RX_FILL, 32'h1);
        chk({afc, rts_n, fen}, 3'b101);
        pul(4'h2, 1);
        rc(OFS_RX_FILL, 32'h2);
        chk(rts_n, 1'b1);
    endtask : t_rts
    task automatic t_ctrl();
        wrt(OFS_SOFT_RESET, 16'h0001);
        @(negedge clk_i) chk(crst, 1'b1);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) chk(crst, 1'b0);
        rc(OFS_SEND_SHADOW, 32'h0);
        rc(OFS_RX_FILL, 32'h0);
        chk(rts_n, 1'b1);
    endtask : t_ctrl
    task automatic conclude();
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_fill();
        t_irq();
        t_queue_ctrl();
        t_rts();
        t_ctrl();
        conclude();
    end
endmodule : uart_fifo_status_reset_shadow_bench
`default_nettype wire
